// file: include/rx_queue_pkg.sv
// Purpose: Shared constants for the receive queue pointer and buffer logic.
// Assumes: 32-bit programmed I/O at word-aligned byte addresses.
// Notes:   Offsets are full physical byte addresses.
package rx_queue_pkg;
  localparam logic [27:0] HOST_ADDR_OFFSET   = 28'h8C04008;
  localparam logic [27:0] FILL_PTR_OFFSET    = 28'h8C0400C;
  localparam logic [27:0] START_PTR_OFFSET   = 28'h8C04010;
  localparam logic [27:0] DRAIN_PTR_OFFSET   = 28'h8C04014;
  localparam logic [27:0] FRAME_CNT_OFFSET   = 28'h8C04018;
  localparam logic [27:0] ENGINE_ST_OFFSET   = 28'h8C0401C;
  localparam logic [27:0] LOWER_WIN_BASE     = 28'h8C05000;
  localparam logic [27:0] UPPER_WIN_BASE     = 28'h8C05800;
  localparam logic [27:0] WIN_SPAN           = 28'h0000800;
  localparam int          ADDR_W             = 28;
  localparam int          PTR_W              = 9;
  localparam int          CNT_W              = 8;
  localparam int          DATA_W             = 32;
  localparam int          DEPTH              = 512;
  localparam logic [27:0] HOST_ADDR_RESET    = 28'h0000000;
  localparam logic [8:0]  PTR_RESET          = 9'h000;
  localparam logic [7:0]  CNT_RESET          = 8'h00;
  localparam int          ST_LOAD_LSB        = 0;
  localparam int          ST_PTR_LSB         = 5;
  localparam int          ST_CSUM_LSB        = 7;
  localparam int          ST_DATA_LSB        = 16;
  localparam int          ST_DESC_LSB        = 20;
  localparam int          ST_DONE_LSB        = 24;
  typedef enum logic [1:0] {
    BURST_1 = 2'h0,
    BURST_2 = 2'h1,
    BURST_4 = 2'h2
  } burst_size_t;
endpackage

// file: include/queue_mem_if.sv
// Purpose: Carries address, data and strobes into the queue storage.
// Assumes: One clock shared with the controller.
// Notes:   Three ports: receive fill, host drain and diagnostic access.
`timescale 1ns/1ps
`default_nettype none
interface queue_mem_if #(parameter int AW = 9, parameter int DW = 33);
  logic          fill_we;
  logic [AW-1:0] fill_addr;
  logic [DW-1:0] fill_data;
  logic [AW-1:0] drain_addr;
  logic [DW-1:0] drain_data;
  logic          diag_we;
  logic [AW-1:0] diag_addr;
  logic [DW-1:0] diag_wdata;
  logic [DW-1:0] diag_rdata;
  modport ctrl (output fill_we, fill_addr, fill_data, drain_addr, diag_we, diag_addr,
                diag_wdata, input drain_data, diag_rdata);
  modport mem  (input fill_we, fill_addr, fill_data, drain_addr, diag_we, diag_addr,
                diag_wdata, output drain_data, diag_rdata);
endinterface
`default_nettype wire

// file: design/queue_storage.sv
// Purpose: The 512 x 33 receive queue memory core.
// Assumes: Diagnostic writes never coincide with live fill traffic.
// Notes:   Read data leave through registers, one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module queue_storage #(
  parameter int DEPTH = 512,
  parameter int AW    = 9,
  parameter int DW    = 33
) (
  input  wire logic CLK_I,
  input  wire logic ce_i,
  queue_mem_if.mem  m
);
  logic [DW-1:0] store [DEPTH];
  logic [DW-1:0] drain_reg;
  logic [DW-1:0] diag_reg;

  // Diagnostic port wins a write clash; software is told to stay off during traffic.
  always_ff @(posedge CLK_I) begin
    if (ce_i) begin
      if (m.diag_we) begin
        store[m.diag_addr] <= m.diag_wdata;
      end else if (m.fill_we) begin
        store[m.fill_addr] <= m.fill_data;
      end
      drain_reg <= store[m.drain_addr];
      diag_reg  <= store[m.diag_addr];
    end
  end

  assign m.drain_data = drain_reg;
  assign m.diag_rdata = diag_reg;
endmodule
`default_nettype wire

// file: design/rx_queue_ctrl.sv
// Purpose: Receive queue pointers, frame count, host address and diagnostics.
// Assumes: Fill and drain requests come from same-clock logic.
// Notes:   Register access is a one-cycle strobe with a registered answer.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Host address counter, 28 bits, adds 1, 2 or 4 after each burst.
// - Host address counter loads the descriptor buffer address during fetch.
// - Host address counter drives burst address; software reads it only.
// - Fill pointer addresses next stored word, advancing 1 or 2.
// - Early abort reloads fill pointer from the frame start pointer.
// - Frame start pointer takes fill pointer when a frame finishes storing.
// - Drain pointer addresses queue reads, advancing 1 or 2 per read.
// - Eight-bit frame count rises on stored frame, falls on delivered frame.
// - Host transfer of a frame starts only with a nonzero frame count.
// - Read-only engine state word with fixed fields, other bits zero.
// - Diagnostic view of the queue is 512 locations of 33 bits.
// - Lower window write clears tag, upper window write sets tag.
// - Lower window read gives data, upper window read gives tag on bit 0.
module rx_queue_ctrl
  import rx_queue_pkg::*;
#(
  parameter int DEPTH_P = DEPTH
) (
  // Clock, reset, enable
  input  wire logic              CLK_I,
  input  wire logic              SYS_RST_I,
  input  wire logic              CE_I,
  // Programmed I/O
  input  wire logic              PIO_REQ_I,
  input  wire logic              PIO_WR_I,
  input  wire logic [ADDR_W-1:0] PIO_ADDR_I,
  input  wire logic [DATA_W-1:0] PIO_WDATA_I,
  output logic                   PIO_ACK_O,
  output logic [DATA_W-1:0]      PIO_RDATA_O,
  // Receive media controller fill side
  input  wire logic              FILL_VALID_I,
  input  wire logic [DATA_W:0]   FILL_DATA_I,
  input  wire logic              FILL_DOUBLE_I,
  input  wire logic              FRAME_STORED_I,
  input  wire logic              EARLY_ABORT_I,
  // Host DMA drain side
  input  wire logic              DRAIN_READ_I,
  input  wire logic              DRAIN_DOUBLE_I,
  input  wire logic              FRAME_DELIVERED_I,
  input  wire logic              DESC_LOAD_I,
  input  wire logic [ADDR_W-1:0] DESC_ADDR_I,
  input  wire logic              BURST_DONE_I,
  input  wire logic [1:0]        BURST_SIZE_I,
  input  wire logic [31:0]       ENGINE_STATES_I,
  output logic                   FRAME_READY_O,
  output logic [ADDR_W-1:0]      BURST_ADDR_O,
  output logic [PTR_W-1:0]       DRAIN_ADDR_O,
  output logic [DATA_W:0]        DRAIN_DATA_O
);
  queue_mem_if #(.AW(PTR_W), .DW(DATA_W + 1)) mif ();

  queue_storage #(.DEPTH(DEPTH_P), .AW(PTR_W), .DW(DATA_W + 1)) u_store (
    .CLK_I (CLK_I),
    .ce_i  (CE_I),
    .m     (mif)
  );

  logic [ADDR_W-1:0] host_addr_reg;
  logic [ADDR_W-1:0] host_addr_next;
  logic [PTR_W-1:0]  fill_ptr_reg;
  logic [PTR_W-1:0]  fill_ptr_next;
  logic [PTR_W-1:0]  start_ptr_reg;
  logic [PTR_W-1:0]  start_ptr_next;
  logic [PTR_W-1:0]  drain_ptr_reg;
  logic [PTR_W-1:0]  drain_ptr_next;
  logic [CNT_W-1:0]  frame_cnt_reg;
  logic [CNT_W-1:0]  frame_cnt_next;
  logic [31:0]       states_reg;
  logic [31:0]       states_next;
  logic              ack_reg;
  logic              ack_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic              diag_pend_reg;
  logic              diag_pend_next;
  logic              diag_upper_reg;
  logic              diag_upper_next;
  logic              ready_reg;
  logic              ready_next;
  logic [DATA_W:0]   drain_data_reg;
  logic [DATA_W:0]   drain_data_next;
  logic [PTR_W-1:0]  drain_addr_reg;
  logic [PTR_W-1:0]  drain_addr_next;

  logic              wr_fill;
  logic              wr_start;
  logic              wr_drain;
  logic              wr_cnt;
  logic              in_lower;
  logic              in_upper;
  logic [PTR_W-1:0]  win_index;

  // Pointer steps of 1 or 2 wrap naturally in nine bits.
  always_comb begin
    wr_fill  = PIO_REQ_I && PIO_WR_I && (PIO_ADDR_I == FILL_PTR_OFFSET);
    wr_start = PIO_REQ_I && PIO_WR_I && (PIO_ADDR_I == START_PTR_OFFSET);
    wr_drain = PIO_REQ_I && PIO_WR_I && (PIO_ADDR_I == DRAIN_PTR_OFFSET);
    wr_cnt   = PIO_REQ_I && PIO_WR_I && (PIO_ADDR_I == FRAME_CNT_OFFSET);
    in_lower = (PIO_ADDR_I >= LOWER_WIN_BASE) && (PIO_ADDR_I < UPPER_WIN_BASE);
    in_upper = (PIO_ADDR_I >= UPPER_WIN_BASE) && (PIO_ADDR_I < UPPER_WIN_BASE + WIN_SPAN);
    win_index = PIO_ADDR_I[PTR_W+1:2];
  end

  always_comb begin
    host_addr_next = host_addr_reg;
    if (DESC_LOAD_I) begin
      host_addr_next = DESC_ADDR_I;
    end else if (BURST_DONE_I) begin
      case (BURST_SIZE_I)
        BURST_2: host_addr_next = host_addr_reg + 28'h0000002;
        BURST_4: host_addr_next = host_addr_reg + 28'h0000004;
        default: host_addr_next = host_addr_reg + 28'h0000001;
      endcase
    end
  end

  always_comb begin
    fill_ptr_next = fill_ptr_reg;
    if (EARLY_ABORT_I) begin
      fill_ptr_next = start_ptr_reg;
    end else if (FILL_VALID_I) begin
      fill_ptr_next = fill_ptr_reg + (FILL_DOUBLE_I ? 9'h002 : 9'h001);
    end else if (wr_fill) begin
      fill_ptr_next = PIO_WDATA_I[PTR_W-1:0];
    end

    start_ptr_next = start_ptr_reg;
    if (FRAME_STORED_I && !EARLY_ABORT_I) begin
      start_ptr_next = fill_ptr_next;
    end else if (wr_start) begin
      start_ptr_next = PIO_WDATA_I[PTR_W-1:0];
    end

    drain_ptr_next = drain_ptr_reg;
    if (DRAIN_READ_I) begin
      drain_ptr_next = drain_ptr_reg + (DRAIN_DOUBLE_I ? 9'h002 : 9'h001);
    end else if (wr_drain) begin
      drain_ptr_next = PIO_WDATA_I[PTR_W-1:0];
    end
  end

  // An aborted frame never reaches the count, so its stored pulse is dropped.
  always_comb begin
    frame_cnt_next = frame_cnt_reg;
    if (FRAME_STORED_I && !EARLY_ABORT_I && !FRAME_DELIVERED_I) begin
      frame_cnt_next = frame_cnt_reg + 8'h01;
    end else if (FRAME_DELIVERED_I && !(FRAME_STORED_I && !EARLY_ABORT_I)) begin
      frame_cnt_next = frame_cnt_reg - 8'h01;
    end else if (FRAME_STORED_I || FRAME_DELIVERED_I) begin
      frame_cnt_next = frame_cnt_reg;
    end else if (wr_cnt) begin
      frame_cnt_next = PIO_WDATA_I[CNT_W-1:0];
    end
  end

  always_comb begin
    // Reserved positions are forced to zero.
    states_next = 32'h00000000;
    states_next[ST_LOAD_LSB +: 5] = ENGINE_STATES_I[ST_LOAD_LSB +: 5];
    states_next[ST_PTR_LSB +: 2]  = ENGINE_STATES_I[ST_PTR_LSB +: 2];
    states_next[ST_CSUM_LSB +: 3] = ENGINE_STATES_I[ST_CSUM_LSB +: 3];
    states_next[ST_DATA_LSB +: 4] = ENGINE_STATES_I[ST_DATA_LSB +: 4];
    states_next[ST_DESC_LSB +: 4] = ENGINE_STATES_I[ST_DESC_LSB +: 4];
    states_next[ST_DONE_LSB +: 2] = ENGINE_STATES_I[ST_DONE_LSB +: 2];
  end

  always_comb begin
    ready_next      = (frame_cnt_next != CNT_RESET);
    drain_addr_next = drain_ptr_next;
    drain_data_next = mif.drain_data;
  end

  // Diagnostic reads take one extra cycle since storage answers from a register.
  always_comb begin
    ack_next        = 1'b0;
    rdata_next      = 32'h00000000;
    diag_pend_next  = 1'b0;
    diag_upper_next = 1'b0;
    if (diag_pend_reg) begin
      ack_next = 1'b1;
      if (diag_upper_reg) begin
        rdata_next = {31'h00000000, mif.diag_rdata[DATA_W]};
      end else begin
        rdata_next = mif.diag_rdata[DATA_W-1:0];
      end
    end else if (PIO_REQ_I) begin
      if (!PIO_WR_I && (in_lower || in_upper)) begin
        diag_pend_next  = 1'b1;
        diag_upper_next = in_upper;
      end else begin
        ack_next = 1'b1;
        if (PIO_WR_I) begin
          rdata_next = 32'h00000000;
        end else if (PIO_ADDR_I == HOST_ADDR_OFFSET) begin
          rdata_next = {4'h0, host_addr_reg};
        end else if (PIO_ADDR_I == FILL_PTR_OFFSET) begin
          rdata_next = {23'h000000, fill_ptr_reg};
        end else if (PIO_ADDR_I == START_PTR_OFFSET) begin
          rdata_next = {23'h000000, start_ptr_reg};
        end else if (PIO_ADDR_I == DRAIN_PTR_OFFSET) begin
          rdata_next = {23'h000000, drain_ptr_reg};
        end else if (PIO_ADDR_I == FRAME_CNT_OFFSET) begin
          rdata_next = {24'h000000, frame_cnt_reg};
        end else if (PIO_ADDR_I == ENGINE_ST_OFFSET) begin
          rdata_next = states_reg;
        end else begin
          rdata_next = 32'h00000000;
        end
      end
    end
  end

  always_comb begin
    mif.fill_we    = FILL_VALID_I && !EARLY_ABORT_I;
    mif.fill_addr  = fill_ptr_reg;
    mif.fill_data  = FILL_DATA_I;
    mif.drain_addr = drain_ptr_reg;
    mif.diag_addr  = win_index;
    mif.diag_we    = PIO_REQ_I && PIO_WR_I && !diag_pend_reg && (in_lower || in_upper);
    mif.diag_wdata = {in_upper, PIO_WDATA_I};
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      host_addr_reg <= HOST_ADDR_RESET;
    end else if (CE_I) begin
      host_addr_reg <= host_addr_next;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      fill_ptr_reg  <= PTR_RESET;
      start_ptr_reg <= PTR_RESET;
      drain_ptr_reg <= PTR_RESET;
    end else if (CE_I) begin
      fill_ptr_reg  <= fill_ptr_next;
      start_ptr_reg <= start_ptr_next;
      drain_ptr_reg <= drain_ptr_next;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      frame_cnt_reg <= CNT_RESET;
    end else if (CE_I) begin
      frame_cnt_reg <= frame_cnt_next;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      states_reg <= 32'h00000000;
    end else if (CE_I) begin
      states_reg <= states_next;
    end
  end

  // Host-side outputs are registered so the engine never sees decode glitches.
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ready_reg      <= 1'b0;
      drain_data_reg <= 33'h000000000;
      drain_addr_reg <= PTR_RESET;
    end else if (CE_I) begin
      ready_reg      <= ready_next;
      drain_data_reg <= drain_data_next;
      drain_addr_reg <= drain_addr_next;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ack_reg        <= 1'b0;
      rdata_reg      <= 32'h00000000;
      diag_pend_reg  <= 1'b0;
      diag_upper_reg <= 1'b0;
    end else if (CE_I) begin
      ack_reg        <= ack_next;
      rdata_reg      <= rdata_next;
      diag_pend_reg  <= diag_pend_next;
      diag_upper_reg <= diag_upper_next;
    end
  end

  assign PIO_ACK_O     = ack_reg;
  assign PIO_RDATA_O   = rdata_reg;
  assign FRAME_READY_O = ready_reg;
  assign BURST_ADDR_O  = host_addr_reg;
  assign DRAIN_ADDR_O  = drain_addr_reg;
  assign DRAIN_DATA_O  = drain_data_reg;
endmodule
`default_nettype wire

// file: verification/rx_queue_checks_assertions.sv
// Purpose: Port-level checks on the receive queue controller.
// Assumes: One programmed access in flight, request held one cycle.
// Notes:   Bound to rx_queue_ctrl below the module.
`timescale 1ns/1ps
`default_nettype none
module rx_queue_checks
  import rx_queue_pkg::*;
(
  // Clock and reset
  input wire logic              CLK_I,
  input wire logic              SYS_RST_I,
  input wire logic              CE_I,
  // Programmed I/O
  input wire logic              PIO_REQ_I,
  input wire logic              PIO_WR_I,
  input wire logic [ADDR_W-1:0] PIO_ADDR_I,
  input wire logic              PIO_ACK_O,
  input wire logic [DATA_W-1:0] PIO_RDATA_O,
  // Fill and drain side
  input wire logic              FRAME_STORED_I,
  input wire logic              EARLY_ABORT_I,
  input wire logic              FRAME_DELIVERED_I,
  input wire logic              DRAIN_READ_I,
  input wire logic              DRAIN_DOUBLE_I,
  input wire logic              DESC_LOAD_I,
  input wire logic [ADDR_W-1:0] DESC_ADDR_I,
  input wire logic              BURST_DONE_I,
  input wire logic [1:0]        BURST_SIZE_I,
  input wire logic              FRAME_READY_O,
  input wire logic [ADDR_W-1:0] BURST_ADDR_O,
  input wire logic [PTR_W-1:0]  DRAIN_ADDR_O
);
  logic [ADDR_W-1:0] step;
  logic              up_rd;
  // Size code 3 counts as one, as the design chose.
  assign step  = (BURST_SIZE_I == 2'h2) ? 28'h4 : (BURST_SIZE_I == 2'h1) ? 28'h2 : 28'h1;
  assign up_rd = PIO_REQ_I && !PIO_WR_I && PIO_ADDR_I >= UPPER_WIN_BASE
                 && PIO_ADDR_I < UPPER_WIN_BASE + WIN_SPAN;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  burst_step_a: assert property (CE_I && BURST_DONE_I && !DESC_LOAD_I |=>
    BURST_ADDR_O == $past(BURST_ADDR_O) + $past(step)) else $error("burst step wrong");
  desc_load_a: assert property (CE_I && DESC_LOAD_I |=>
    BURST_ADDR_O == $past(DESC_ADDR_I)) else $error("descriptor load missed");
  addr_hold_a: assert property (!(CE_I && (DESC_LOAD_I || BURST_DONE_I)) |=>
    $stable(BURST_ADDR_O)) else $error("host address moved");
  drain_step_a: assert property (CE_I && DRAIN_READ_I && !PIO_REQ_I |=>
    DRAIN_ADDR_O == $past(DRAIN_ADDR_O) + ($past(DRAIN_DOUBLE_I) ? 9'h2 : 9'h1))
    else $error("drain step wrong");
  window_tag_a: assert property (CE_I && up_rd |-> ##2 PIO_ACK_O && PIO_RDATA_O[31:1] == '0)
    else $error("upper window read wrong");
  state_mask_a: assert property (CE_I && PIO_REQ_I && !PIO_WR_I
    && PIO_ADDR_I == ENGINE_ST_OFFSET |=> PIO_ACK_O && (PIO_RDATA_O & 32'hFC00FC00) == '0)
    else $error("state word reserved bits set");
  ready_set_a: assert property (CE_I && FRAME_STORED_I && !EARLY_ABORT_I
    && !FRAME_DELIVERED_I |=> FRAME_READY_O) else $error("frame ready not raised");
  ready_cause_a: assert property ($rose(FRAME_READY_O) |->
    $past(FRAME_STORED_I) || ($past(PIO_REQ_I) && $past(PIO_WR_I)))
    else $error("ready without frame");
  cover property (up_rd);
  cover property (FRAME_STORED_I && FRAME_DELIVERED_I);
  cover property (EARLY_ABORT_I);
endmodule
bind rx_queue_ctrl rx_queue_checks u_checks (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .CE_I(CE_I),
  .PIO_REQ_I(PIO_REQ_I), .PIO_WR_I(PIO_WR_I), .PIO_ADDR_I(PIO_ADDR_I), .PIO_ACK_O(PIO_ACK_O),
  .PIO_RDATA_O(PIO_RDATA_O), .FRAME_STORED_I(FRAME_STORED_I), .EARLY_ABORT_I(EARLY_ABORT_I),
  .FRAME_DELIVERED_I(FRAME_DELIVERED_I), .DRAIN_READ_I(DRAIN_READ_I),
  .DRAIN_DOUBLE_I(DRAIN_DOUBLE_I), .DESC_LOAD_I(DESC_LOAD_I), .DESC_ADDR_I(DESC_ADDR_I),
  .BURST_DONE_I(BURST_DONE_I), .BURST_SIZE_I(BURST_SIZE_I), .FRAME_READY_O(FRAME_READY_O),
  .BURST_ADDR_O(BURST_ADDR_O), .DRAIN_ADDR_O(DRAIN_ADDR_O));
`default_nettype wire

// file: verification/rx_far_side.sv
// Purpose: Media controller and host engine strobes toward the queue.
// Assumes: Strobes launched at the falling edge, one cycle each.
// Notes:   After a pulse, fill data and descriptor address show the inverse so stale values never match.
`timescale 1ns/1ps
`default_nettype none
module rx_far_side (
  // Clock
  input  wire logic   clk_i,
  // Strobes and data toward the controller
  output logic [8:0]  strobe_o,
  output logic [32:0] fill_data_o,
  output logic [27:0] desc_addr_o,
  output logic [1:0]  burst_size_o
);
  initial begin
    strobe_o = '0;
    fill_data_o = '0;
    desc_addr_o = '0;
    burst_size_o = 2'h0;
  end
  task automatic pulse(input logic [8:0] s, input logic [32:0] d, input logic [27:0] a,
                       input logic [1:0] z);
    @(negedge clk_i);
    strobe_o = s;
    fill_data_o = d;
    desc_addr_o = a;
    burst_size_o = z;
    @(negedge clk_i);
    strobe_o = '0;
    fill_data_o = ~d;
    desc_addr_o = ~a;
  endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Purpose: Register and pointer scenarios for the receive queue controller.
// Assumes: Inputs change at the falling edge.
// Notes:   Diagnostic windows are used only while the strobes are idle.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rx_queue_pkg::*;
  localparam logic [8:0] FILL = 9'h001, FDBL = 9'h002, STORED = 9'h004, ABORT = 9'h008;
  localparam logic [8:0] DRAIN = 9'h010, DDBL = 9'h020, DELIV = 9'h040, DESC = 9'h080;
  localparam logic [8:0] BURST = 9'h100;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, req = 1'b0, wr = 1'b0;
  logic [27:0] addr = '0, exp_a, ba, da;
  logic [31:0] wdata = '0, rdata, got, eng = 32'hFFFFFFFF;
  logic [32:0] fd, drd;
  logic [8:0]  s, dra;
  logic [1:0]  bs;
  logic        ack, ready;
  int          n_mismatch = 0, comparisons = 0, cycles = 0, i;
  always #12.5 clk = ~clk;
  rx_far_side u_far (.clk_i(clk), .strobe_o(s), .fill_data_o(fd), .desc_addr_o(da),
    .burst_size_o(bs));
  rx_queue_ctrl u_dut (.CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .PIO_REQ_I(req),
    .PIO_WR_I(wr), .PIO_ADDR_I(addr), .PIO_WDATA_I(wdata), .PIO_ACK_O(ack),
    .PIO_RDATA_O(rdata), .FILL_VALID_I(s[0]), .FILL_DATA_I(fd), .FILL_DOUBLE_I(s[1]),
    .FRAME_STORED_I(s[2]), .EARLY_ABORT_I(s[3]), .DRAIN_READ_I(s[4]), .DRAIN_DOUBLE_I(s[5]),
    .FRAME_DELIVERED_I(s[6]), .DESC_LOAD_I(s[7]), .DESC_ADDR_I(da), .BURST_DONE_I(s[8]),
    .BURST_SIZE_I(bs), .ENGINE_STATES_I(eng), .FRAME_READY_O(ready), .BURST_ADDR_O(ba),
    .DRAIN_ADDR_O(dra), .DRAIN_DATA_O(drd));
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // A hung handshake gives up in acc after four more cycles; this ceiling caps the whole run.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [27:0] a, input logic [31:0] d);
    int k;
    @(negedge clk);
    req = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    @(negedge clk);
    req = 1'b0;
    for (k = 0; k < 4 && ack !== 1'b1; k++) @(negedge clk);
    got = rdata;
  endtask
  task automatic rc(input logic [27:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), {1'b0, e}, {1'b0, got});
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    rc(HOST_ADDR_OFFSET, 32'h0);
    rc(FRAME_CNT_OFFSET, 32'h0);
    acc(1'b1, ENGINE_ST_OFFSET, 32'h0);
    rc(ENGINE_ST_OFFSET, 32'h03FF03FF);
    rc(28'h8C04020, 32'h0);
    $display("test reset_layout done");
    u_far.pulse(DESC, 33'h0, 28'hFFFFFFE, 2'h0);
    acc(1'b1, HOST_ADDR_OFFSET, 32'h5);
    exp_a = 28'hFFFFFFE;
    for (i = 0; i < 4; i++) begin
      u_far.pulse(BURST, 33'h0, 28'h0, i[1:0]);
      exp_a = exp_a + ((i == 2) ? 28'h4 : (i == 1) ? 28'h2 : 28'h1);
      rc(HOST_ADDR_OFFSET, {4'h0, exp_a});
      chk("BURST_ADDR_O", {5'h0, exp_a}, {5'h0, ba});
    end
    ce = 1'b0;
    u_far.pulse(BURST, 33'h0, 28'h0, 2'h2);
    ce = 1'b1;
    rc(HOST_ADDR_OFFSET, {4'h0, exp_a});
    $display("test host_address done");
    for (i = 0; i < 3; i++) u_far.pulse(FILL, {1'b0, 32'hC0DE0000 + i}, 28'h0, 2'h0);
    u_far.pulse(FILL | FDBL, 33'h0, 28'h0, 2'h0);
    u_far.pulse(STORED, 33'h0, 28'h0, 2'h0);
    rc(FILL_PTR_OFFSET, 32'h5);
    rc(START_PTR_OFFSET, 32'h5);
    rc(FRAME_CNT_OFFSET, 32'h1);
    chk("FRAME_READY_O", 33'h1, {32'h0, ready});
    u_far.pulse(FILL | FDBL, 33'h0, 28'h0, 2'h0);
    u_far.pulse(ABORT, 33'h0, 28'h0, 2'h0);
    rc(FILL_PTR_OFFSET, 32'h5);
    u_far.pulse(STORED | DELIV, 33'h0, 28'h0, 2'h0);
    rc(FRAME_CNT_OFFSET, 32'h1);
    u_far.pulse(DELIV, 33'h0, 28'h0, 2'h0);
    rc(FRAME_CNT_OFFSET, 32'h0);
    chk("FRAME_READY_O", 33'h0, {32'h0, ready});
    acc(1'b1, FILL_PTR_OFFSET, 32'h1FF);
    u_far.pulse(FILL | FDBL, 33'h0, 28'h0, 2'h0);
    rc(FILL_PTR_OFFSET, 32'h1);
    $display("test fill_frames done");
    // Strobes stay idle through the window tests, so the windows are safe to use.
    acc(1'b1, 28'h8C057FC, 32'hA5A5A5A5);
    rc(28'h8C057FC, 32'hA5A5A5A5);
    rc(28'h8C05FFC, 32'h0);
    acc(1'b1, 28'h8C0580C, 32'h12345678);
    rc(28'h8C0580C, 32'h1);
    rc(28'h8C0500C, 32'h12345678);
    rc(28'h8C05004, 32'hC0DE0001);
    $display("test windows done");
    acc(1'b1, DRAIN_PTR_OFFSET, 32'h1FF);
    repeat (3) @(negedge clk);
    chk("DRAIN_DATA_O", {1'b0, 32'hA5A5A5A5}, drd);
    u_far.pulse(DRAIN | DDBL, 33'h0, 28'h0, 2'h0);
    rc(DRAIN_PTR_OFFSET, 32'h1);
    chk("DRAIN_ADDR_O", 33'h001, {24'h0, dra});
    chk("DRAIN_DATA_O", {1'b0, 32'hC0DE0001}, drd);
    $display("test drain done");
    close_out();
  end
endmodule
`default_nettype wire
